// File: rtl/gpio_waveform_generator.sv
// General purpose pad block with waveform generator and aux sampling.
// How it works
// - Twelve pads, each controlled on its own.
// - Own gateable clock domain, enable bit.
// - Pads change at most every toggle interval.
// - Direct write drives pads once completed.
// - Started waveforms run without further commands.
// - Waveform end raises wakeup and status bit.
// - Wakeup reaches microcontroller only while sleeping.
// - Any pad can be a high-impedance input.
// - Pad levels readable in one register.
// - Blanking-time converter samples three aux inputs.
// - Aux sampling limited to about 36000/s.
// - Host and microcontroller share both control methods.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_consts.svh"
module gpio_waveform_generator
  import gpio_pkg::*;
#(
  parameter int NPADS = 12,
  parameter int PW    = 16,
  parameter int AW    = 10
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [7:0]       paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [NPADS-1:0] pad_in,
  output logic      [NPADS-1:0] pad_out,
  output logic      [NPADS-1:0] pad_oe,
  input  wire logic             mcu_sleep,
  input  wire logic             hblank,
  input  wire logic             adc_ack,
  input  wire logic [AW-1:0]    adc_data,
  output logic                  adc_req,
  output logic      [1:0]       adc_sel,
  output logic                  wakeup,
  output logic                  irq
);
  typedef struct packed {
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 en;
    logic                 wave;
    logic                 start;
    logic                 stop;
    logic [NPADS-1:0]     level;
    logic [NPADS-1:0]     dir;
    logic [NPADS-1:0]     wlevel;
    logic [PW-1:0]        period;
    logic [NPADS-1:0]     wmask;
    logic [PW-1:0]        wcount;
    logic [1:0]           status;
    logic [1:0]           imask;
    logic [2:0][AW-1:0]   aux;
    logic [NPADS-1:0]     pad_out;
    logic [NPADS-1:0]     pad_oe;
    logic [NPADS-1:0]     sync1;
    logic [NPADS-1:0]     sync2;
    logic                 slp1;
    logic                 slp2;
    logic [1:0]           tick_cnt;
    logic                 wakeup;
    logic                 irq;
    adc_state_type        adc_state;
    logic                 adc_req;
    logic [1:0]           adc_sel;
    logic [11:0]          gap;
  } blk_state_type;

  blk_state_type st_ff;
  blk_state_type nxt_st;
  logic          acc;
  logic          tick;

  wave_if #(.CW(PW)) w();

  wave_timer #(.CW(PW)) u_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .w       (w.timer)
  );

  // The tick paces every pad level change (pad_oe follows DIR without it) and stands still while gated.
  assign acc  = psel & penable;
  assign tick = st_ff.en && st_ff.tick_cnt == 2'(`TOGGLE_CYC - 1);

  // Timer inputs; leaving waveform mode also stops it, gating off only withholds ticks.
  assign w.start  = st_ff.start;
  assign w.stop   = st_ff.stop | ~st_ff.wave;
  assign w.tick   = tick;
  assign w.period = st_ff.period;
  assign w.count  = st_ff.wcount;

  // Next state: bus slave, pads, waveform, aux sampling and events.
  always_comb begin
    logic        hit;
    logic [31:0] rd;
    logic        wr_done;
    logic        rd_clr;
    logic [1:0]  ev;
    hit = 1'b1;
    rd = 32'h0000_0000;
    wr_done = acc & st_ff.pready & pwrite;
    rd_clr = acc & st_ff.pready & ~pwrite & (paddr == `OFS_STATUS);
    ev = 2'h0;
    nxt_st = st_ff;
    nxt_st.start = 1'b0;
    nxt_st.stop = 1'b0;
    // Read decode; unmapped offsets read zero and flag an error.
    case (paddr)
      `OFS_CTRL:   rd = 32'({st_ff.wave, st_ff.en});
      `OFS_LEVEL:  rd = 32'(st_ff.level);
      `OFS_DIR:    rd = 32'(st_ff.dir);
      `OFS_STATE:  rd = 32'(st_ff.sync2);
      `OFS_PERIOD: rd = 32'(st_ff.period);
      `OFS_WMASK:  rd = 32'(st_ff.wmask);
      `OFS_WCOUNT: rd = 32'(st_ff.wcount);
      `OFS_STATUS: rd = 32'(st_ff.status);
      `OFS_IMASK:  rd = 32'(st_ff.imask);
      `OFS_AUX0:   rd = 32'(st_ff.aux[0]);
      `OFS_AUX1:   rd = 32'(st_ff.aux[1]);
      `OFS_AUX2:   rd = 32'(st_ff.aux[2]);
      default:     hit = 1'b0;
    endcase
    // Every access waits exactly one cycle so read data can be a flop.
    nxt_st.pready = acc & ~st_ff.pready;
    if (acc & ~st_ff.pready) begin
      nxt_st.prdata = rd;
      nxt_st.pslverr = ~hit;
    end
    // Writes land only on the completing edge, from host or MCU alike.
    if (wr_done) begin
      case (paddr)
        `OFS_CTRL: begin
          nxt_st.en = pwdata[`CTRL_EN_BIT];
          nxt_st.wave = pwdata[`CTRL_WAVE_BIT];
          nxt_st.start = pwdata[`CTRL_START_BIT];
          nxt_st.stop = pwdata[`CTRL_STOP_BIT];
        end
        `OFS_LEVEL:  nxt_st.level = pwdata[NPADS-1:0];
        `OFS_DIR:    nxt_st.dir = pwdata[NPADS-1:0];
        `OFS_PERIOD: nxt_st.period = pwdata[PW-1:0];
        `OFS_WMASK:  nxt_st.wmask = pwdata[NPADS-1:0];
        `OFS_WCOUNT: nxt_st.wcount = pwdata[PW-1:0];
        `OFS_IMASK:  nxt_st.imask = pwdata[1:0];
        default:     nxt_st.imask = st_ff.imask;
      endcase
    end
    // Pin and sleep synchronisers.
    nxt_st.sync1 = pad_in;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.slp1 = mcu_sleep;
    nxt_st.slp2 = st_ff.slp1;
    // Tick divider freezes while the block clock is gated.
    if (st_ff.en) begin
      nxt_st.tick_cnt = tick ? 2'h0 : st_ff.tick_cnt + 2'h1;
    end
    // Waveform image starts from the direct levels, then toggles.
    if (st_ff.start) begin
      nxt_st.wlevel = st_ff.level;
    end else if (w.toggle) begin
      nxt_st.wlevel = st_ff.wlevel ^ st_ff.wmask;
    end
    // Pad levels update only on a tick, drive enables every cycle; each bit is independent.
    if (tick) begin
      nxt_st.pad_out = st_ff.wave ? st_ff.wlevel : st_ff.level;
    end
    nxt_st.pad_oe = ~st_ff.dir;
    // Aux converter: sample during blanking, then hold off the gap.
    case (st_ff.adc_state)
      AD_IDLE: begin
        if (hblank && st_ff.en) begin
          nxt_st.adc_req = 1'b1;
          nxt_st.adc_state = AD_WAIT;
        end
      end
      AD_WAIT: begin
        if (adc_ack) begin
          nxt_st.aux[st_ff.adc_sel] = adc_data;
          nxt_st.adc_req = 1'b0;
          nxt_st.adc_sel = (st_ff.adc_sel == 2'h2) ? 2'h0
                                                   : st_ff.adc_sel + 2'h1;
          nxt_st.gap = 12'(`AUX_GAP_CYC - 1);
          nxt_st.adc_state = AD_GAP;
          ev[`ST_ADC_BIT] = 1'b1;
        end
      end
      AD_GAP: begin
        nxt_st.gap = st_ff.gap - 12'h001;
        if (st_ff.gap == 12'h000) begin
          nxt_st.adc_state = AD_IDLE;
        end
      end
      default: begin
        nxt_st.adc_req = 1'b0;
        nxt_st.adc_state = AD_IDLE;
      end
    endcase
    // Sticky status: a new event beats a same-cycle read clear.
    ev[`ST_WEND_BIT] = w.done;
    // The clear takes only the bits that this read reported, so an event
    // that lands between data capture and completion is not lost.
    nxt_st.status = (st_ff.status & ~(st_ff.prdata[1:0] & {2{rd_clr}}))
                    | ev;
    nxt_st.irq = |(nxt_st.status & st_ff.imask);
    // Wakeup only matters to a sleeping MCU, so it is gated by sleep.
    nxt_st.wakeup = w.done & st_ff.slp2;
  end

  // State register; pads start as inputs driving low.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.dir <= `DIR_RST;
      st_ff.adc_state <= AD_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata  = st_ff.prdata;
  assign pready  = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign pad_out = st_ff.pad_out;
  assign pad_oe  = st_ff.pad_oe;
  assign adc_req = st_ff.adc_req;
  assign adc_sel = st_ff.adc_sel;
  assign wakeup  = st_ff.wakeup;
  assign irq     = st_ff.irq;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence lvl_write;
    acc && pready && pwrite && paddr == `OFS_LEVEL && st_ff.en
      && !st_ff.wave;
  endsequence

  sequence lvl_seen;
    ##[1:5] pad_out == st_ff.level;
  endsequence

  apb_answer_a: assert property (acc && !pready |=> pready)
    else $error("APB access not answered after one wait cycle");

  apb_unmapped_a: assert property (acc && !pready
    && paddr > `OFS_AUX2 |=> pslverr && prdata == 32'h0000_0000)
    else $error("Unmapped access did not error");

  toggle_space_a: assert property ($changed(pad_out)
    |=> !$changed(pad_out) [*2])
    else $error("Pads changed faster than the toggle interval");

  direct_level_a: assert property (lvl_write |-> lvl_seen)
    else $error("Direct level write did not reach the pads");

  gate_hold_a: assert property (!st_ff.en |=> $stable(pad_out))
    else $error("Pads moved while the block was gated");

  gate_suspend_a: assert property (!st_ff.en
    |=> !w.toggle && !w.done && $stable(st_ff.tick_cnt))
    else $error("Waveform advanced while gated");

  pad_dir_a: assert property (1 |=> pad_oe == ~$past(st_ff.dir))
    else $error("Pad drive enable does not follow direction");

  wake_cause_a: assert property (wakeup
    |-> $past(w.done) && $past(st_ff.slp2))
    else $error("Wakeup without waveform end or while awake");

  end_status_a: assert property (w.done
    |=> st_ff.status[`ST_WEND_BIT])
    else $error("Waveform end did not set its status bit");

  pad_mirror_a: assert property (##2 1
    |-> st_ff.sync2 == $past(pad_in, 2))
    else $error("Pad state register lags the pins wrongly");

  adc_blank_a: assert property ($rose(adc_req)
    |-> $past(hblank) && $past(st_ff.en))
    else $error("Aux sample requested outside blanking");

  adc_gap_a: assert property (st_ff.adc_state == AD_WAIT
    && adc_ack |=> st_ff.adc_state == AD_GAP && !adc_req
        && st_ff.gap == 12'(`AUX_GAP_CYC - 1))
    else $error("Aux sample gap not enforced");

  irq_level_a: assert property (irq
    == |(st_ff.status & $past(st_ff.imask)))
    else $error("Interrupt does not match masked status");

  status_keep_a: assert property ($fell(st_ff.status[`ST_WEND_BIT])
    |-> $past(acc && pready && !pwrite && paddr == `OFS_STATUS
        && prdata[`ST_WEND_BIT]))
    else $error("Wave end status cleared without being reported");
endmodule // gpio_waveform_generator
`default_nettype wire

// File: rtl/gpio_consts.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH
`define OFS_CTRL       8'h00
`define OFS_LEVEL      8'h04
`define OFS_DIR        8'h08
`define OFS_STATE      8'h0C
`define OFS_PERIOD     8'h10
`define OFS_WMASK      8'h14
`define OFS_WCOUNT     8'h18
`define OFS_STATUS     8'h1C
`define OFS_IMASK      8'h20
`define OFS_AUX0       8'h24
`define OFS_AUX1       8'h28
`define OFS_AUX2       8'h2C
`define CTRL_EN_BIT    0
`define CTRL_WAVE_BIT  1
`define CTRL_START_BIT 2
`define CTRL_STOP_BIT  3
`define ST_WEND_BIT    0
`define ST_ADC_BIT     1
`define DIR_RST        12'hFFF
`define CLK_MHZ        100
`define TOGGLE_MIN_NS  25
`define TOGGLE_CYC     ((`TOGGLE_MIN_NS * `CLK_MHZ + 999) / 1000)
`define AUX_MAX_SPS    36000
`define AUX_GAP_CYC    ((`CLK_MHZ * 1000000 + `AUX_MAX_SPS - 1) / `AUX_MAX_SPS)
`endif

// File: rtl/gpio_pkg.sv
// Types shared by the waveform generator modules.
package gpio_pkg;
  typedef enum logic [1:0] {
    WT_IDLE = 2'h1,
    WT_RUN  = 2'h2
  } wave_state_type;
  typedef enum logic [2:0] {
    AD_IDLE = 3'h1,
    AD_WAIT = 3'h2,
    AD_GAP  = 3'h4
  } adc_state_type;
endpackage

// File: rtl/wave_if.sv
// Control and event signals between the register block and the timer.
`timescale 1ns/1ps
`default_nettype none
interface wave_if #(parameter int CW = 16);
  logic          start;
  logic          stop;
  logic          tick;
  logic [CW-1:0] period;
  logic [CW-1:0] count;
  logic          toggle;
  logic          done;
  logic          busy;
  modport timer (input start, stop, tick, period, count,
                 output toggle, done, busy);
  modport ctrl  (output start, stop, tick, period, count,
                 input toggle, done, busy);
endinterface
`default_nettype wire

// File: rtl/wave_timer.sv
// Period timer that paces the autonomous waveform.
`timescale 1ns/1ps
`default_nettype none
module wave_timer
  import gpio_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  wave_if.timer    w
);
  typedef struct packed {
    wave_state_type state;
    logic [CW-1:0]  cnt;
    logic [CW-1:0]  reps;
    logic           toggle;
    logic           done;
  } timer_state_type;

  timer_state_type st_ff;
  timer_state_type nxt_st;

  // Counts ticks to the period end, toggles, and ends after count periods.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.toggle = 1'b0;
    nxt_st.done = 1'b0;
    case (st_ff.state)
      WT_IDLE: begin
        if (w.start) begin
          nxt_st.state = WT_RUN;
          nxt_st.cnt = '0;
          nxt_st.reps = '0;
        end
      end
      WT_RUN: begin
        if (w.stop) begin
          nxt_st.state = WT_IDLE;
        end else if (w.tick) begin
          if (w.period == '0 || st_ff.cnt == w.period - CW'(1)) begin
            nxt_st.cnt = '0;
            nxt_st.toggle = 1'b1;
            // A zero count means the waveform repeats forever.
            if (w.count != '0 && st_ff.reps == w.count - CW'(1)) begin
              nxt_st.done = 1'b1;
              nxt_st.state = WT_IDLE;
            end else begin
              nxt_st.reps = st_ff.reps + CW'(1);
            end
          end else begin
            nxt_st.cnt = st_ff.cnt + CW'(1);
          end
        end
      end
      default: begin
        nxt_st.state = WT_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{WT_IDLE, '0, '0, 1'b0, 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign w.toggle = st_ff.toggle;
  assign w.done   = st_ff.done;
  assign w.busy   = (st_ff.state == WT_RUN);
endmodule // wave_timer
`default_nettype wire

// File: test/pad_partner.sv
// Far-side model: pad wires with an external driver, and the aux converter.
`timescale 1ns/1ps
`default_nettype none
module pad_partner (
  input  wire logic        ref_clk,
  input  wire logic [11:0] pad_out,
  input  wire logic [11:0] pad_oe,
  input  wire logic [11:0] ext_val,
  output logic      [11:0] pad_in,
  input  wire logic        adc_req,
  input  wire logic [1:0]  adc_sel,
  input  wire logic [9:0]  adc_base,
  input  wire logic [3:0]  adc_lat,
  output logic             adc_ack,
  output logic      [9:0]  adc_data
);
  logic [3:0] wait_ff = 4'h0;
  // A pad follows the block while enabled, else the far device drives it.
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_val);
  // The converter answers each request once, after a chosen delay.
  // Outside the answer the data lines flip, so stale data never matches.
  initial begin
    adc_ack  = 1'b0;
    adc_data = 10'h0;
  end
  always @(posedge ref_clk) begin
    adc_ack  <= 1'b0;
    adc_data <= ~adc_data;
    if (adc_req === 1'b1 && !adc_ack && wait_ff == adc_lat) begin
      adc_ack  <= 1'b1;
      adc_data <= adc_base + 10'(adc_sel);
      wait_ff  <= 4'h0;
    end else if (adc_req === 1'b1 && !adc_ack) begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule // pad_partner
`default_nettype wire

// File: test/gpio_waveform_generator_test.sv
// Self-checking bench: registers, pads, waveform, wakeup, aux sampling.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_consts.svh"
module gpio_waveform_generator_test;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        mcu_sleep, hblank, adc_ack, adc_req, wakeup, irq, serr;
  logic        req_prev;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] pad_in, pad_out, pad_oe, ext_val, prev_pad, lvl, wm;
  logic [9:0]  adc_data, adc_base;
  logic [3:0]  adc_lat;
  logic [1:0]  adc_sel;
  int          err_total, cmp_count, wk_cnt, acks, wk0, seed, i;
  int          chg_gap = 99;
  int          ack_gap = 99999;

  gpio_waveform_generator DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .mcu_sleep(mcu_sleep), .hblank(hblank), .adc_ack(adc_ack),
    .adc_data(adc_data), .adc_req(adc_req), .adc_sel(adc_sel),
    .wakeup(wakeup), .irq(irq));
  pad_partner far_side (
    .ref_clk(ref_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .ext_val(ext_val), .pad_in(pad_in), .adc_req(adc_req),
    .adc_sel(adc_sel), .adc_base(adc_base), .adc_lat(adc_lat),
    .adc_ack(adc_ack), .adc_data(adc_data));

  // Verdict and run end; every exit of the bench comes through here.
  task automatic end_sim();
    $display("err_total=%0d cmp_count=%0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    err_total++;
    $display("[FAIL] %0t wait ran out", $time);
    end_sim();
  endtask
  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    psel   <= 1'b1;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) hang();
    rd   = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_pads(input logic [11:0] e, input int lim);
    int n;
    n = 0;
    while (pad_out !== e && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    chk(pad_out, e);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // A hang anywhere ends in the same report.
  initial begin
    repeat (60000) @(posedge ref_clk);
    hang();
  end
  // Pads change on ticks only, never closer than the toggle interval.
  always @(posedge ref_clk) begin
    prev_pad <= pad_out;
    chg_gap  <= chg_gap + 1;
    if (rst_n === 1'b1 && pad_out !== prev_pad) begin
      chk(32'(chg_gap >= `TOGGLE_CYC), 32'h1);
      chg_gap <= 1;
    end
  end
  // Counts wakeups and answers; a new request must respect the gap.
  always @(posedge ref_clk) begin
    if (wakeup === 1'b1) wk_cnt++;
    ack_gap++;
    if (adc_req === 1'b1 && req_prev !== 1'b1)
      chk(32'(ack_gap >= `AUX_GAP_CYC), 32'h1);
    if (adc_ack === 1'b1) begin
      acks++;
      ack_gap = 0;
    end
    req_prev = adc_req;
  end

  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, mcu_sleep, hblank} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    ext_val = 12'h0;
    adc_base = 10'h0;
    adc_lat = 4'h0;
    seed = $urandom(32'h24C6);
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk({pad_out, pad_oe}, 32'h0);
    chk({irq, wakeup, adc_req}, 32'h0);
    apb(1'b0, `OFS_DIR, 0);
    chk(rd, 32'hFFF);
    // Released pads: the far device drives them and STATE follows.
    for (i = 0; i < 4; i++) begin
      ext_val <= (i == 0) ? 12'hFFF : 12'($urandom);
      repeat (4) @(posedge ref_clk);
      apb(1'b0, `OFS_STATE, 0);
      chk(rd, 32'(ext_val));
    end
    apb(1'b1, `OFS_STATE, 32'h1);
    chk(serr, 1'b0);
    apb(1'b1, 8'h40, 32'h5A);
    chk(serr, 1'b1);
    apb(1'b0, 8'h40, 0);
    chk(rd, 32'h0);
    // Direct control: each pad on its own, then random words.
    apb(1'b1, `OFS_CTRL, 32'h1);
    apb(1'b1, `OFS_DIR, 32'h0FE);
    repeat (2) @(posedge ref_clk);
    chk(pad_oe, 12'hF01);
    apb(1'b1, `OFS_DIR, 32'h0);
    lvl = 12'h0;
    for (i = 0; i < 14; i++) begin
      lvl = (i < 12) ? lvl ^ (12'h1 << i) : 12'($urandom);
      apb(1'b1, `OFS_LEVEL, 32'(lvl));
      wait_pads(lvl, 6);
      repeat (2) @(posedge ref_clk);
      apb(1'b0, `OFS_STATE, 0);
      chk(rd, 32'(lvl));
    end
    chk(pad_oe, 12'hFFF);
    // Waveform with the controller asleep: toggles, one wakeup, irq.
    mcu_sleep <= 1'b1;
    wm = 12'($urandom) | 12'h801;
    apb(1'b1, `OFS_PERIOD, 32'h2);
    apb(1'b1, `OFS_WMASK, 32'(wm));
    apb(1'b1, `OFS_WCOUNT, 32'h3);
    apb(1'b1, `OFS_IMASK, 32'h1);
    wk0 = wk_cnt;
    apb(1'b1, `OFS_CTRL, 32'h7);
    wait_pads(lvl ^ wm, 50);
    for (i = 0; i < 200 && wk_cnt == wk0; i++) @(posedge ref_clk);
    repeat (5) @(posedge ref_clk);
    chk(wk_cnt - wk0, 1);
    chk(irq, 1'b1);
    apb(1'b0, `OFS_STATUS, 0);
    chk(rd & 32'h1, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    // Controller awake and interrupt masked: the status bit only.
    mcu_sleep <= 1'b0;
    apb(1'b1, `OFS_IMASK, 32'h0);
    wk0 = wk_cnt;
    apb(1'b1, `OFS_CTRL, 32'h7);
    repeat (100) @(posedge ref_clk);
    chk(wk_cnt - wk0, 0);
    chk(irq, 1'b0);
    apb(1'b1, `OFS_IMASK, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b1);
    apb(1'b0, `OFS_STATUS, 0);
    chk(rd & 32'h1, 32'h1);
    apb(1'b0, `OFS_STATUS, 0);
    chk(rd, 32'h0);
    chk(irq, 1'b0);
    // Endless waveform, then the block clock gated off: pads hold.
    lvl = ~lvl;
    apb(1'b1, `OFS_LEVEL, 32'(lvl));
    apb(1'b1, `OFS_WCOUNT, 32'h0);
    apb(1'b1, `OFS_CTRL, 32'h7);
    wait_pads(lvl ^ wm, 50);
    apb(1'b1, `OFS_CTRL, 32'h2);
    repeat (2) @(posedge ref_clk);
    lvl = pad_out;
    for (i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      chk(pad_out, lvl);
    end
    apb(1'b1, `OFS_CTRL, 32'h9);
    // Aux sampling in blanking; converter delay drawn at random.
    adc_base <= 10'($urandom);
    adc_lat  <= 4'($urandom);
    apb(1'b1, `OFS_CTRL, 32'h1);
    hblank <= 1'b1;
    for (i = 0; i < 12000 && acks < 3; i++) @(posedge ref_clk);
    if (acks < 3) hang();
    hblank <= 1'b0;
    for (i = 0; i < 3; i++) begin
      apb(1'b0, 8'(`OFS_AUX0 + 4 * i), 0);
      chk(rd, 32'(10'(adc_base + 10'(i))));
    end
    apb(1'b0, `OFS_STATUS, 0);
    chk(rd & 32'h2, 32'h2);
    end_sim();
  end
endmodule // gpio_waveform_generator_test
`default_nettype wire
